// *** src/safety_block_monitor.sv ***
// Purpose: Safety stop supervision of a servo drive with an Avalon-MM register slave.
// Assumes: Safety pins high means ON; position deltas come from logic on I_REF_CLK.
// Notes:   Every bus transfer takes two cycles; waitrequest drops in the second.
//
// The register addresses and the Avalon-MM interface to the registers were left to the implementer.
`include "safety_block_params.svh"

// How it works
// RULE_01 - The monitor output is on only while both safety stop inputs are off.
// RULE_02 - The monitor output follows an input change well within 20 ms.
// RULE_03 - In the safety block state the deviation is cleared or kept as the clear select says.
// RULE_04 - With clear select 1, host commands keep adding to the deviation in the safety block.
// RULE_05 - With clear select 1, the clear input zeroes the deviation in safety or base block.
// RULE_06 - A deviation beyond the limit raises the overflow alarm.
// RULE_07 - The servo alarm output stays off in the safety block state.
// RULE_08 - The host should stop sending position commands during the safety block.
// RULE_09 - The safety unit refuses reset and flags a failure if the monitor stays off.
// RULE_10 - The on/off state of both safety stop inputs can be read by software.
// RULE_11 - With both inputs off the safety block indication shows and the motor is disabled.
// RULE_12 - The host stops the motor and servo before the guard opens and restores it after.
// RULE_13 - Either input off places the drive in the safety block state.
// RULE_14 - Off pulses of 0.5 ms or less on either input are ignored.
// RULE_15 - Only one input changing raises the safety timing alarm.
// RULE_16 - Both inputs on with servo-on released leads to base block, then servo-on works.
// RULE_17 - Both inputs are synchronised before any decision uses them.
module safety_block_monitor #(
    parameter int OFF_FILTER_CYCLES = `SBM_OFF_FILTER_US * `SBM_CLK_MHZ,
    parameter int MISMATCH_CYCLES   = `SBM_MISMATCH_US * `SBM_CLK_MHZ
) (
    input  wire logic        I_REF_CLK,
    input  wire logic        I_RESETN,
    input  wire logic        I_SAFETY_STOP_INPUT_A,
    input  wire logic        I_SAFETY_STOP_INPUT_B,
    input  wire logic        I_SERVO_ON,
    input  wire logic        I_DEVIATION_CLEAR_INPUT,
    input  wire logic        I_DRIVE_FAULT,
    input  wire logic        I_POS_CMD_VALID,
    input  wire logic [15:0] I_POS_CMD_DELTA,
    input  wire logic        I_POS_FB_VALID,
    input  wire logic [15:0] I_POS_FB_DELTA,
    input  wire logic [4:0]  I_AVS_ADDRESS,
    input  wire logic        I_AVS_READ,
    input  wire logic        I_AVS_WRITE,
    input  wire logic [31:0] I_AVS_WRITEDATA,
    input  wire logic [3:0]  I_AVS_BYTEENABLE,
    output logic [31:0]      O_AVS_READDATA,
    output logic             O_AVS_WAITREQUEST,
    output logic             O_SAFETY_MONITOR_OUTPUT,
    output logic             O_SERVO_ALARM_OUTPUT,
    output logic             O_SAFETY_BLOCK_DISPLAY,
    output logic             O_MOTOR_ENABLE,
    output logic             O_HARD_WIRED_BASE_BLOCK,
    output logic             O_BASE_BLOCK_STATE,
    output logic             O_DEVIATION_OVERFLOW_ALARM,
    output logic             O_SAFETY_TIMING_ALARM
);

    localparam int DEADLINE_CYCLES = `SBM_MONITOR_DEADLINE_MS * 1000 * `SBM_CLK_MHZ;

    // The filter plus the synchroniser and output stages must fit the monitor deadline.
    if (OFF_FILTER_CYCLES < 1 || MISMATCH_CYCLES < 1 ||
        OFF_FILTER_CYCLES + 8 > DEADLINE_CYCLES) begin : g_bad_params // RULE_02
        $error("filter or mismatch count outside the usable range");
    end

    // ****************************************************************
    // Helpers
    // ****************************************************************
    function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                               input logic [31:0] new_v,
                                               input logic [3:0]  be);
        logic [31:0] r;
        r = old_v;
        for (int i = 0; i < 4; i++) begin
            if (be[i]) begin
                r[i*8 +: 8] = new_v[i*8 +: 8];
            end
        end
        return r;
    endfunction : lane_merge

    function automatic logic [31:0] magnitude(input logic signed [31:0] v);
        return v[31] ? 32'(-v) : 32'(v);
    endfunction : magnitude

    // ****************************************************************
    // Input qualification
    // ****************************************************************
    logic f_a_on;
    logic f_b_on;
    logic f_servo_on;
    logic f_clear;

    safety_input_qualifier #(.OFF_FILTER_CYCLES(OFF_FILTER_CYCLES)) u_input_a (
        .i_clk    (I_REF_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_SAFETY_STOP_INPUT_A),
        .o_on     (f_a_on)
    );
    safety_input_qualifier #(.OFF_FILTER_CYCLES(OFF_FILTER_CYCLES)) u_input_b (
        .i_clk    (I_REF_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_SAFETY_STOP_INPUT_B),
        .o_on     (f_b_on)
    );
    safety_input_qualifier #(.OFF_FILTER_CYCLES(0)) u_servo_on (
        .i_clk    (I_REF_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_SERVO_ON),
        .o_on     (f_servo_on)
    );
    safety_input_qualifier #(.OFF_FILTER_CYCLES(0)) u_clear (
        .i_clk    (I_REF_CLK),
        .i_resetn (I_RESETN),
        .i_pin    (I_DEVIATION_CLEAR_INPUT),
        .o_on     (f_clear)
    );

    // ****************************************************************
    // State
    // ****************************************************************
    safety_block_pkg::monitor_state_type st;
    safety_block_pkg::monitor_state_type next_st;

    logic signed [31:0] cmd_ext;
    logic signed [31:0] fb_ext;
    logic               ovf_set;
    logic               tim_set;
    logic               any_alarm;
    logic               do_write;
    logic [31:0]        status_word;
    logic [31:0]        ctrl_word;

    assign cmd_ext = {{16{I_POS_CMD_DELTA[15]}}, I_POS_CMD_DELTA};
    assign fb_ext  = {{16{I_POS_FB_DELTA[15]}}, I_POS_FB_DELTA};

    always_comb begin
        next_st   = st;
        ovf_set   = magnitude(st.deviation) > st.limit; // RULE_06
        tim_set   = st.mis_cnt == 32'(MISMATCH_CYCLES);
        any_alarm = st.ovf_alarm || st.timing_alarm || I_DRIVE_FAULT;
        do_write  = st.ack && I_AVS_WRITE;

        if (!f_a_on || !f_b_on) begin
            next_st.op = safety_block_pkg::ST_HARD_WIRED_BASE_BLOCK; // RULE_13
        end else begin
            unique case (st.op)
                safety_block_pkg::ST_HARD_WIRED_BASE_BLOCK: begin
                    if (!f_servo_on) begin
                        next_st.op = safety_block_pkg::ST_BASE_BLOCK; // RULE_16
                    end
                end
                safety_block_pkg::ST_BASE_BLOCK: begin
                    if (f_servo_on && !any_alarm) begin
                        next_st.op = safety_block_pkg::ST_RUNNING; // RULE_16
                    end
                end
                safety_block_pkg::ST_RUNNING: begin
                    if (!f_servo_on || any_alarm) begin
                        next_st.op = safety_block_pkg::ST_BASE_BLOCK;
                    end
                end
            endcase
        end

        if (st.op == safety_block_pkg::ST_HARD_WIRED_BASE_BLOCK && !st.clear_select) begin
            next_st.deviation = 32'sh0; // RULE_03
        end else if (st.op != safety_block_pkg::ST_RUNNING && st.clear_select && f_clear) begin
            next_st.deviation = 32'sh0; // RULE_05
        end else begin
            // Feedback only counts while the motor runs; blocked, commands pile up.
            next_st.deviation = st.deviation
                + (I_POS_CMD_VALID ? cmd_ext : 32'sh0)
                - ((I_POS_FB_VALID && st.op == safety_block_pkg::ST_RUNNING) ?
                   fb_ext : 32'sh0); // RULE_04
        end

        if (f_a_on != f_b_on) begin
            if (!tim_set) begin
                next_st.mis_cnt = st.mis_cnt + 32'h1; // RULE_15
            end
        end else begin
            next_st.mis_cnt = 32'h0;
        end

        status_word = 32'h0;
        status_word[`SBM_STAT_INPUT_A_BIT]     = f_a_on; // RULE_10
        status_word[`SBM_STAT_INPUT_B_BIT]     = f_b_on; // RULE_10
        status_word[`SBM_STAT_SAFE_BLOCK_BIT]  =
            st.op == safety_block_pkg::ST_HARD_WIRED_BASE_BLOCK;
        status_word[`SBM_STAT_BASE_BLOCK_BIT]  = st.op == safety_block_pkg::ST_BASE_BLOCK;
        status_word[`SBM_STAT_RUNNING_BIT]     = st.op == safety_block_pkg::ST_RUNNING;
        status_word[`SBM_STAT_MONITOR_BIT]     = st.monitor;
        status_word[`SBM_STAT_OVERFLOW_BIT]    = st.ovf_alarm;
        status_word[`SBM_STAT_TIMING_BIT]      = st.timing_alarm;
        status_word[`SBM_STAT_SERVO_ALARM_BIT] = st.alarm_out;

        // Alarms clear by writing one; a new event in the same cycle wins.
        next_st.ovf_alarm    = ovf_set || (st.ovf_alarm &&
            !(do_write && I_AVS_ADDRESS == `SBM_OFS_STATUS && I_AVS_BYTEENABLE[0] &&
              I_AVS_WRITEDATA[`SBM_STAT_OVERFLOW_BIT]));
        next_st.timing_alarm = tim_set || (st.timing_alarm &&
            !(do_write && I_AVS_ADDRESS == `SBM_OFS_STATUS && I_AVS_BYTEENABLE[0] &&
              I_AVS_WRITEDATA[`SBM_STAT_TIMING_BIT]));

        next_st.ack     = (I_AVS_READ || I_AVS_WRITE) && !st.ack;
        next_st.waitreq = !next_st.ack;
        if (!st.ack && I_AVS_READ) begin
            unique case (I_AVS_ADDRESS)
                `SBM_OFS_CONTROL:   next_st.rdata = {31'h0, st.clear_select};
                `SBM_OFS_LIMIT:     next_st.rdata = st.limit;
                `SBM_OFS_STATUS:    next_st.rdata = status_word;
                `SBM_OFS_DEVIATION: next_st.rdata = st.deviation;
                default:            next_st.rdata = 32'h0;
            endcase
        end
        ctrl_word = lane_merge({31'h0, st.clear_select}, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        if (do_write && I_AVS_ADDRESS == `SBM_OFS_CONTROL) begin
            next_st.clear_select = ctrl_word[`SBM_CTRL_CLEAR_SELECT_BIT];
        end
        if (do_write && I_AVS_ADDRESS == `SBM_OFS_LIMIT) begin
            next_st.limit = lane_merge(st.limit, I_AVS_WRITEDATA, I_AVS_BYTEENABLE);
        end

        next_st.monitor   = !f_a_on && !f_b_on; // RULE_01
        next_st.display   = next_st.op == safety_block_pkg::ST_HARD_WIRED_BASE_BLOCK; // RULE_11
        next_st.motor_en  = next_st.op == safety_block_pkg::ST_RUNNING; // RULE_11
        next_st.alarm_out = (next_st.ovf_alarm || next_st.timing_alarm || I_DRIVE_FAULT) &&
                            next_st.op != safety_block_pkg::ST_HARD_WIRED_BASE_BLOCK; // RULE_07
    end

    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            st              <= '0;
            st.op           <= safety_block_pkg::ST_HARD_WIRED_BASE_BLOCK;
            st.display      <= 1'b1;
            st.waitreq      <= 1'b1;
            st.limit        <= `SBM_LIMIT_RESET;
            st.clear_select <= `SBM_CLEAR_SELECT_RESET;
        end else begin
            st <= next_st;
        end
    end

    assign O_AVS_READDATA             = st.rdata;
    assign O_AVS_WAITREQUEST          = st.waitreq;
    assign O_SAFETY_MONITOR_OUTPUT    = st.monitor;
    assign O_SERVO_ALARM_OUTPUT       = st.alarm_out;
    assign O_SAFETY_BLOCK_DISPLAY     = st.display;
    assign O_MOTOR_ENABLE             = st.motor_en;
    assign O_HARD_WIRED_BASE_BLOCK    = st.op == safety_block_pkg::ST_HARD_WIRED_BASE_BLOCK;
    assign O_BASE_BLOCK_STATE         = st.op == safety_block_pkg::ST_BASE_BLOCK;
    assign O_DEVIATION_OVERFLOW_ALARM = st.ovf_alarm;
    assign O_SAFETY_TIMING_ALARM      = st.timing_alarm;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    logic [31:0] lag;
    always_ff @(posedge I_REF_CLK or negedge I_RESETN) begin
        if (!I_RESETN) begin
            lag <= 32'h0;
        end else if (st.monitor == (!I_SAFETY_STOP_INPUT_A && !I_SAFETY_STOP_INPUT_B)) begin
            lag <= 32'h0;
        end else begin
            lag <= lag + 32'h1;
        end
    end

    default clocking cb @(posedge I_REF_CLK); endclocking
    default disable iff (!I_RESETN);

    property p_monitor_only_both_off;
        (f_a_on || f_b_on) |=> !O_SAFETY_MONITOR_OUTPUT;
    endproperty
    a_monitor_only_both_off : assert property (p_monitor_only_both_off) // RULE_01
        else $error("monitor on while an input is on");

    property p_monitor_deadline;
        lag < 32'(DEADLINE_CYCLES);
    endproperty
    a_monitor_deadline : assert property (p_monitor_deadline) // RULE_02
        else $error("monitor output late");

    property p_block_clears;
        (O_HARD_WIRED_BASE_BLOCK && !st.clear_select) |=> st.deviation == 32'sh0;
    endproperty
    a_block_clears : assert property (p_block_clears) // RULE_03
        else $error("deviation kept with clearing selected");

    property p_block_accumulates;
        (O_HARD_WIRED_BASE_BLOCK && st.clear_select && !f_clear && I_POS_CMD_VALID)
            |=> st.deviation == $past(st.deviation) + $past(cmd_ext);
    endproperty
    a_block_accumulates : assert property (p_block_accumulates) // RULE_04
        else $error("command lost in safety block");

    property p_clear_input;
        (!O_MOTOR_ENABLE && st.clear_select && f_clear) |=> st.deviation == 32'sh0;
    endproperty
    a_clear_input : assert property (p_clear_input) // RULE_05
        else $error("clear input ignored");

    property p_overflow;
        (magnitude(st.deviation) > st.limit) |=> O_DEVIATION_OVERFLOW_ALARM;
    endproperty
    a_overflow : assert property (p_overflow) // RULE_06
        else $error("overflow alarm missing");

    property p_no_alarm_in_block;
        O_HARD_WIRED_BASE_BLOCK |-> !O_SERVO_ALARM_OUTPUT && O_SAFETY_BLOCK_DISPLAY &&
                                   !O_MOTOR_ENABLE;
    endproperty
    a_no_alarm_in_block : assert property (p_no_alarm_in_block) // RULE_07
        else $error("alarm, display or motor wrong in safety block");

    property p_enter_block;
        (!f_a_on || !f_b_on) |=> O_HARD_WIRED_BASE_BLOCK;
    endproperty
    a_enter_block : assert property (p_enter_block) // RULE_13
        else $error("safety block not entered");

    property p_leave_block;
        (O_HARD_WIRED_BASE_BLOCK && f_a_on && f_b_on)
            |=> (!$past(f_servo_on) ? O_BASE_BLOCK_STATE : O_HARD_WIRED_BASE_BLOCK);
    endproperty
    a_leave_block : assert property (p_leave_block) // RULE_16
        else $error("wrong exit from safety block");

    property p_timing_alarm;
        (f_a_on != f_b_on) [*2] ##0 (st.mis_cnt == 32'(MISMATCH_CYCLES)) |=>
            O_SAFETY_TIMING_ALARM;
    endproperty
    a_timing_alarm : assert property (p_timing_alarm) // RULE_15
        else $error("timing alarm missing");

    c_enter_block  : cover property ($rose(O_HARD_WIRED_BASE_BLOCK));
    c_reach_base   : cover property ($rose(O_BASE_BLOCK_STATE) ##[1:20] O_MOTOR_ENABLE);
    c_timing_alarm : cover property ($rose(O_SAFETY_TIMING_ALARM));
    c_overflow     : cover property ($rose(O_DEVIATION_OVERFLOW_ALARM));

endmodule : safety_block_monitor

// *** src/safety_block_params.svh ***
// Purpose: Clock rate and times, register offsets, field positions and reset values of the
//          safety block monitor.
// Assumes: Included by its bare name from the design files.
// Notes:   Definitions only.
`ifndef SAFETY_BLOCK_PARAMS_SVH
`define SAFETY_BLOCK_PARAMS_SVH

// ****************************************************************
// Timing
// ****************************************************************
`define SBM_CLK_MHZ             100
`define SBM_OFF_FILTER_US       500
`define SBM_MISMATCH_US         10000
`define SBM_MONITOR_DEADLINE_MS 20

// ****************************************************************
// Register offsets (byte addresses)
// ****************************************************************
`define SBM_OFS_CONTROL   5'h00
`define SBM_OFS_LIMIT     5'h04
`define SBM_OFS_STATUS    5'h08
`define SBM_OFS_DEVIATION 5'h0C

// ****************************************************************
// Fields and reset values
// ****************************************************************
`define SBM_CTRL_CLEAR_SELECT_BIT 0
`define SBM_STAT_INPUT_A_BIT      0
`define SBM_STAT_INPUT_B_BIT      1
`define SBM_STAT_SAFE_BLOCK_BIT   2
`define SBM_STAT_BASE_BLOCK_BIT   3
`define SBM_STAT_RUNNING_BIT      4
`define SBM_STAT_MONITOR_BIT      5
`define SBM_STAT_OVERFLOW_BIT     6
`define SBM_STAT_TIMING_BIT       7
`define SBM_STAT_SERVO_ALARM_BIT  8
`define SBM_LIMIT_RESET           32'h0050_0000
`define SBM_CLEAR_SELECT_RESET    1'h0

`endif

// *** src/safety_block_pkg.sv ***
// Purpose: Types shared by the safety block monitor files.
// Assumes: Nothing is imported; users write safety_block_pkg::name.
// Notes:   Numbers live in safety_block_params.svh.
package safety_block_pkg;

    typedef enum logic [1:0] {
        ST_BASE_BLOCK,
        ST_RUNNING,
        ST_HARD_WIRED_BASE_BLOCK
    } op_state_type;

    typedef struct packed {
        logic        ff1;
        logic        ff2;
        logic        ff3;
        logic        level;
        logic        on;
        logic [31:0] cnt;
    } qualifier_state_type;

    typedef struct packed {
        op_state_type       op;
        logic               clear_select;
        logic [31:0]        limit;
        logic signed [31:0] deviation;
        logic               ovf_alarm;
        logic               timing_alarm;
        logic [31:0]        mis_cnt;
        logic               ack;
        logic               waitreq;
        logic [31:0]        rdata;
        logic               monitor;
        logic               alarm_out;
        logic               display;
        logic               motor_en;
    } monitor_state_type;

endpackage : safety_block_pkg

// *** src/safety_input_qualifier.sv ***
// Purpose: Brings one pin into the clock domain and rejects short off pulses.
// Assumes: Pin high means ON. OFF_FILTER_CYCLES of zero accepts an off level at once.
// Notes:   Output low after reset, so the drive starts in the safe state.
module safety_input_qualifier #(
    parameter int OFF_FILTER_CYCLES = 50000
) (
    input  wire logic i_clk,
    input  wire logic i_resetn,
    input  wire logic i_pin,
    output logic      o_on
);

    if (OFF_FILTER_CYCLES < 0) begin : g_bad_filter
        $error("OFF_FILTER_CYCLES must not be negative");
    end

    safety_block_pkg::qualifier_state_type st;
    safety_block_pkg::qualifier_state_type next_st;

    always_comb begin
        next_st     = st;
        next_st.ff1 = i_pin;
        next_st.ff2 = st.ff1;
        next_st.ff3 = st.ff2;
        if (st.ff2 == st.ff3) begin // RULE_17
            next_st.level = st.ff2;
        end
        if (st.level) begin
            next_st.on  = 1'b1;
            next_st.cnt = 32'h0;
        end else if (st.cnt >= 32'(OFF_FILTER_CYCLES)) begin // RULE_14
            next_st.on = 1'b0;
        end else begin
            next_st.cnt = st.cnt + 32'h1;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn) begin
        if (!i_resetn) begin
            st <= '0;
        end else begin
            st <= next_st;
        end
    end

    assign o_on = st.on;

    // ****************************************************************
    // Assertions
    // ****************************************************************
    property p_off_needs_long_pulse;
        @(posedge i_clk) disable iff (!i_resetn)
        $fell(st.on) |-> ($past(st.cnt) == 32'(OFF_FILTER_CYCLES)) && !$past(st.level);
    endproperty
    a_off_needs_long_pulse : assert property (p_off_needs_long_pulse) // RULE_14
        else $error("off level accepted before the filter time");

    property p_level_agreed;
        @(posedge i_clk) disable iff (!i_resetn)
        $changed(st.level) |-> $past(st.ff2) == $past(st.ff3);
    endproperty
    a_level_agreed : assert property (p_level_agreed) // RULE_17
        else $error("level changed without two agreeing stages");

endmodule : safety_input_qualifier

// *** verif/safety_block_monitor_tb.sv ***
// Purpose: Self-checking bench of the safety block monitor.
// Assumes: Filters are shortened to 20 and 50 cycles; the bus answers after one cycle.
// Notes:   Drive feedback and byte enables are tied.
module safety_block_monitor_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'h0, resetn = 1'h0, servo_on = 1'h0, clr_in = 1'h0, cmd_v = 1'h0;
    logic rd = 1'h0, wr = 1'h0, glitch = 1'h0, guard = 1'h0, stuck = 1'h0, fault = 1'h0;
    logic [15:0] cmd_d = 16'h0;
    logic [4:0]  addr = 5'h0;
    logic [31:0] wdata = 32'h0, rdata, q;
    logic        waitreq, mon, alarm, disp, motor, hard_wired_base_block, bb, ovf, timing, pin_a, pin_b, fail;
    int          n_errors = 0, tests_run = 0, cycles = 0;
    always #5 clk = ~clk;
    safety_unit_model unit (.i_clk(clk), .i_guard_open(guard), .i_stuck_a(stuck),
        .i_monitor(mon), .o_pin_a(pin_a), .o_pin_b(pin_b), .o_fail(fail));
    safety_block_monitor #(.OFF_FILTER_CYCLES(20), .MISMATCH_CYCLES(50)) dut (
        .I_REF_CLK(clk), .I_RESETN(resetn), .I_SAFETY_STOP_INPUT_A(pin_a & ~glitch),
        .I_SAFETY_STOP_INPUT_B(pin_b & ~glitch), .I_SERVO_ON(servo_on),
        .I_DEVIATION_CLEAR_INPUT(clr_in), .I_DRIVE_FAULT(fault), .I_POS_CMD_VALID(cmd_v),
        .I_POS_CMD_DELTA(cmd_d), .I_POS_FB_VALID(1'h0), .I_POS_FB_DELTA(16'h0),
        .I_AVS_ADDRESS(addr), .I_AVS_READ(rd), .I_AVS_WRITE(wr), .I_AVS_WRITEDATA(wdata),
        .I_AVS_BYTEENABLE(4'hF), .O_AVS_READDATA(rdata), .O_AVS_WAITREQUEST(waitreq),
        .O_SAFETY_MONITOR_OUTPUT(mon), .O_SERVO_ALARM_OUTPUT(alarm),
        .O_SAFETY_BLOCK_DISPLAY(disp), .O_MOTOR_ENABLE(motor), .O_HARD_WIRED_BASE_BLOCK(hard_wired_base_block),
        .O_BASE_BLOCK_STATE(bb), .O_DEVIATION_OVERFLOW_ALARM(ovf),
        .O_SAFETY_TIMING_ALARM(timing));
    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", what, exp, got);
        end
    endtask : chk
    task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
        @(posedge clk);
        addr <= a;
        wdata <= d;
        wr <= w;
        rd <= !w;
        do @(posedge clk); while (waitreq !== 1'h0);
        q = rdata;
        rd <= 1'h0;
        wr <= 1'h0;
    endtask : bus
    task automatic upto(ref logic s, input int n);
        for (int k = 0; k < n && s !== 1'h1; k++) @(posedge clk);
    endtask : upto
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict
    // ****************************************************************
    // Scenarios
    // ****************************************************************
    task automatic t_start();
        upto(bb, 30);
        bus(1'h0, 5'h08, 32'h0);
        chk("status", 32'h00B, q);
        bus(1'h0, 5'h10, 32'h0);
        chk("unmapped", 32'h0, q);
        bus(1'h0, 5'h04, 32'h0);
        chk("limit", 32'h0050_0000, q);
        servo_on <= 1'h1;
        upto(motor, 30);
        chk("motor", 32'h1, {31'h0, motor});
        fault <= 1'h1;
        upto(alarm, 10);
        chk("fault alarm", 32'h1, {31'h0, alarm & bb & ~motor});
        fault <= 1'h0;
        upto(motor, 10);
        $display("start done");
    endtask : t_start
    task automatic t_glitch();
        servo_on <= 1'h0;
        upto(bb, 30);
        glitch <= 1'h1;
        repeat (10) @(posedge clk);
        glitch <= 1'h0;
        repeat (40) @(posedge clk);
        chk("glitch", 32'h0, {31'h0, hard_wired_base_block | mon});
        guard <= 1'h1;
        upto(mon, 100);
        chk("monitor", 32'h1, {31'h0, mon});
        chk("display", 32'h1, {31'h0, disp & hard_wired_base_block & ~motor});
        bus(1'h0, 5'h08, 32'h0);
        chk("status", 32'h024, q);
        $display("guard done");
    endtask : t_glitch
    task automatic t_dev();
        bus(1'h1, 5'h00, 32'h1);
        bus(1'h1, 5'h04, 32'hFA);
        servo_on <= 1'h1;
        cmd_d <= 16'h64;
        cmd_v <= 1'h1;
        repeat (3) @(posedge clk);
        cmd_v <= 1'h0;
        bus(1'h0, 5'h0C, 32'h0);
        chk("deviation", 32'h12C, q);
        chk("overflow", 32'h1, {31'h0, ovf});
        chk("alarm", 32'h0, {31'h0, alarm});
        clr_in <= 1'h1;
        repeat (6) @(posedge clk);
        clr_in <= 1'h0;
        bus(1'h0, 5'h0C, 32'h0);
        chk("cleared", 32'h0, q);
        bus(1'h1, 5'h00, 32'h0);
        cmd_v <= 1'h1;
        @(posedge clk);
        cmd_v <= 1'h0;
        bus(1'h0, 5'h0C, 32'h0);
        chk("kept zero", 32'h0, q);
        bus(1'h1, 5'h08, 32'h40);
        @(posedge clk);
        chk("ovf w1c", 32'h0, {31'h0, ovf});
        $display("deviation done");
    endtask : t_dev
    task automatic t_exit();
        guard <= 1'h0;
        repeat (60) @(posedge clk);
        chk("held", 32'h1, {31'h0, hard_wired_base_block & ~mon});
        servo_on <= 1'h0;
        upto(bb, 30);
        chk("base", 32'h1, {31'h0, bb});
        stuck <= 1'h1;
        guard <= 1'h1;
        upto(timing, 300);
        chk("timing", 32'h1, {31'h0, timing});
        chk("one off", 32'h1, {31'h0, hard_wired_base_block & ~mon});
        guard <= 1'h0;
        repeat (5) @(posedge clk);
        chk("unit fail", 32'h1, {31'h0, fail});
        $display("exit done");
    endtask : t_exit
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            give_verdict();
        end
    end
    initial begin
        repeat (6) @(posedge clk);
        resetn <= 1'h1;
        t_start();
        t_glitch();
        t_dev();
        t_exit();
        give_verdict();
    end
endmodule : safety_block_monitor_tb

// *** verif/safety_unit_model.sv ***
// Purpose: Safety unit that drives both stop pins from the guard and reads back the monitor.
// Assumes: Pins high means ON; the bench asks for a stuck channel only in the fault test.
// Notes:   Once a failure is flagged the unit never resets again.
module safety_unit_model (
    input  wire logic i_clk,
    input  wire logic i_guard_open,
    input  wire logic i_stuck_a,
    input  wire logic i_monitor,
    output logic      o_pin_a,
    output logic      o_pin_b,
    output logic      o_fail
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        o_pin_a = 1'h1;
        o_pin_b = 1'h1;
        o_fail = 1'h0;
    end
    always @(posedge i_clk) begin
        if (i_guard_open) begin
            o_pin_a <= i_stuck_a;
            o_pin_b <= 1'h0;
        end else if (!o_pin_b && !o_fail) begin
            // A silent monitor means a welded channel, so the unit refuses reset.
            if (i_monitor === 1'h1) begin
                o_pin_a <= 1'h1;
                o_pin_b <= 1'h1;
            end else begin
                o_fail <= 1'h1;
            end
        end
    end
endmodule : safety_unit_model
